// ### rsb_regs.svh
// Constants for the reserved bit storage register.
// Assumes inclusion by bare name from package and module.
`ifndef RSB_REGS_SVH
`define RSB_REGS_SVH
`define RSB_WIDTH 32
`define RSB_RST_VAL 32'h0000_0000
`define RSB_CTX_RZ_MASK 32'h0000_00f0
`define RSB_RO_RZ_MASK 32'h0000_0f00
`define RSB_R1_HW_MASK 32'h0000_f000
`define RSB_R1_WR_MASK 32'h000f_0000
`endif

// ### rsb_pkg.sv
// Types shared by the reserved bit storage register.
// Assumes rsb_regs.svh is on the include path.
`include "rsb_regs.svh"
package rsb_pkg;
  typedef struct packed {
    logic dir_wr;
    logic ind_wr;
    logic rd;
    logic [`RSB_WIDTH-1:0] data;
  } rsb_req_t;
endpackage : rsb_pkg

// ### rsb_reg.sv
// Register with reserved-zero and reserved-one bits and their storage.
// Assumes requests synchronous to mclk, one request port, no bus.
//
// Summary of operation
// - Unwritten writable reserved bit reads its reset value after reset.
// - Direct write updates the storage element of each writable bit.
// - Context-reserved zero bits reach no function while context is reserved.
// - Read-only reserved zero bits read as zero.
// - Each reserved-one field picks hardwired or writable by its own mask.
// - Hardwired reserved-one bits read one and ignore every write.
// - Indirect write without a same-cycle direct write sets writable reserved-one storage to one.
// - Writable reserved-one bit reads its last direct or indirect write.
// - Writable reserved-one storage affects nothing but its read value.
`timescale 1ns/100ps
`include "rsb_regs.svh"
module rsb_reg
  import rsb_pkg::*;
#(
  parameter int W = `RSB_WIDTH,
  parameter logic [W-1:0] RST_VAL = `RSB_RST_VAL,
  parameter logic [W-1:0] CTX_RZ_MASK = `RSB_CTX_RZ_MASK,
  parameter logic [W-1:0] RO_RZ_MASK = `RSB_RO_RZ_MASK,
  parameter logic [W-1:0] R1_HW_MASK = `RSB_R1_HW_MASK,
  parameter logic [W-1:0] R1_WR_MASK = `RSB_R1_WR_MASK
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire rsb_req_t req,
  input wire logic ctx_rsv,
  output logic [W-1:0] rd_data_q,
  output logic rd_valid_q,
  output logic [W-1:0] func_q
);
  // Bits never stored: hardwired ones and read-only zeros
  localparam logic [W-1:0] FIXED = R1_HW_MASK | RO_RZ_MASK;
  // Bits that steer core logic; all reserved-one bits are excluded
  localparam logic [W-1:0] FUNC = ~(FIXED | R1_WR_MASK);

  logic [W-1:0] store_q;
  logic [W-1:0] store_d;
  logic [W-1:0] rd_data_d;
  logic rd_valid_d;
  logic [W-1:0] func_d;

  // Per-bit storage; one flop per bit, fixed bits keep reset value
  for (genvar i = 0; i < W; i++) begin : g_bit
    always_comb begin
      store_d[i] = store_q[i];
      if (FIXED[i]) begin
        store_d[i] = store_q[i];
      end else if (req.dir_wr) begin
        store_d[i] = req.data[i];
      end else if (req.ind_wr) begin
        if (R1_WR_MASK[i]) begin
          store_d[i] = 1'b1;
        end else if (CTX_RZ_MASK[i] && ctx_rsv) begin
          store_d[i] = 1'b0;
        end else begin
          store_d[i] = req.data[i];
        end
      end
    end
  end

  // Read samples storage before a same-cycle write lands
  always_comb begin
    rd_valid_d = req.rd;
    rd_data_d = rd_data_q;
    if (req.rd) begin
      rd_data_d = (store_q & ~FIXED) | R1_HW_MASK;
    end
    func_d = store_q & FUNC;
    if (ctx_rsv) begin
      func_d = store_q & FUNC & ~CTX_RZ_MASK;
    end
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      store_q <= RST_VAL;
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
      func_q <= '0;
    end else begin
      store_q <= store_d;
      rd_data_q <= rd_data_d;
      rd_valid_q <= rd_valid_d;
      func_q <= func_d;
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Helper: set once any write has landed since reset
  logic wr_seen_q;
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      wr_seen_q <= 1'b0;
    end else if (req.dir_wr || req.ind_wr) begin
      wr_seen_q <= 1'b1;
    end
  end

  a_read_reset_val: assert property (
    req.rd && !wr_seen_q |=> rd_data_q ==
      ((RST_VAL & ~FIXED) | R1_HW_MASK))
    else $error("unwritten read not reset value");
  a_direct_write_store: assert property (
    req.dir_wr ##1 req.rd |=> (rd_data_q & ~FIXED) ==
      ($past(req.data, 2) & ~FIXED))
    else $error("direct write not stored");
  a_ctx_zero_func: assert property (
    $past(ctx_rsv) |-> (func_q & CTX_RZ_MASK) == '0)
    else $error("reserved context bit reached function");
  a_ro_zero_read: assert property (
    rd_valid_q |-> (rd_data_q & RO_RZ_MASK) == '0)
    else $error("read-only zero bit read nonzero");
  a_hw_one_read: assert property (
    req.dir_wr ##1 req.rd |=> (rd_data_q & R1_HW_MASK) == R1_HW_MASK)
    else $error("hardwired one bit not one");
  a_ind_sets_one: assert property (
    req.ind_wr && !req.dir_wr ##1 req.rd |=>
      (rd_data_q & R1_WR_MASK) == R1_WR_MASK)
    else $error("indirect write left writable one clear");
  a_last_write_read: assert property (
    req.dir_wr ##1 (req.rd && !req.dir_wr && !req.ind_wr) |=>
      (rd_data_q & R1_WR_MASK) == ($past(req.data, 2) & R1_WR_MASK))
    else $error("writable one bit lost last write");
  a_one_no_effect: assert property (
    ##1 (func_q & (R1_WR_MASK | R1_HW_MASK)) == '0)
    else $error("reserved one bit reached function");
  a_read_one_pulse: assert property (
    req.rd |=> rd_valid_q ##1 (rd_valid_q == $past(req.rd)))
    else $error("read valid not tied to request");
  // Indirect write in reserved context must clear the context bits
  a_ind_ctx_clear: assert property (
    req.ind_wr && !req.dir_wr && ctx_rsv ##1
      (req.rd && !req.dir_wr && !req.ind_wr) |=>
      (rd_data_q & CTX_RZ_MASK & ~R1_WR_MASK & ~FIXED) == '0)
    else $error("indirect write kept context bit");
  // Fixed bits never follow write data, whatever was written
  a_fixed_ignore_wr: assert property (
    rd_valid_q |-> (rd_data_q & FIXED) == R1_HW_MASK)
    else $error("fixed bit followed a write");
  // Read data only moves when a read was taken
  a_read_hold: assert property (
    !req.rd |=> $stable(rd_data_q))
    else $error("read data moved without a read");

  c_direct_then_read: cover property (req.dir_wr ##1 req.rd);
  c_indirect_then_read: cover property (req.ind_wr ##1 req.rd);
  c_ctx_switch: cover property (!ctx_rsv ##1 ctx_rsv);
  c_ind_in_ctx: cover property (req.ind_wr && ctx_rsv ##1 req.rd);
endmodule : rsb_reg

// ### rsb_reg_test.sv
// Bench for the reserved bit storage register.
// Assumes default masks and a zero reset value.
`timescale 1ns/100ps
`include "rsb_regs.svh"
module rsb_reg_test;
  import rsb_pkg::*;
  typedef logic [`RSB_WIDTH-1:0] rsb_word_t;
  logic mclk, nrst, ctx_rsv, rd_valid_q;
  rsb_req_t req;
  rsb_word_t rd_data_q, func_q;
  int failures = 0, comparisons = 0, cycles = 0;
  rsb_reg dut (.mclk(mclk), .nrst(nrst), .req(req), .ctx_rsv(ctx_rsv),
    .rd_data_q(rd_data_q), .rd_valid_q(rd_valid_q), .func_q(func_q));
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  task automatic finish_test();
    $display("checks %0d mismatches %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : finish_test
  always @(posedge mclk) begin
    cycles++;
    // Whole run needs well under a hundred cycles
    if (cycles == 2000) begin
      failures++;
      finish_test();
    end
  end
  task automatic chk(string what, rsb_word_t exp, rsb_word_t got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : chk
  task automatic wr(logic dir, logic ind, rsb_word_t d);
    @(negedge mclk);
    req = '{dir_wr: dir, ind_wr: ind, rd: 1'b0, data: d};
    @(negedge mclk);
    req = '0;
  endtask : wr
  task automatic rd_chk(rsb_word_t exp);
    @(negedge mclk);
    req.rd = 1'b1;
    @(negedge mclk);
    req.rd = 1'b0;
    chk("rd_valid_q", 32'h0000_0001, {31'h0, rd_valid_q});
    chk("rd_data_q", exp, rd_data_q);
  endtask : rd_chk
  task automatic t_direct();
    rd_chk(32'h0000_f000);
    wr(1'b1, 1'b0, 32'hffff_ffff);
    rd_chk(32'hffff_f0ff);
    wr(1'b1, 1'b0, 32'h0000_0000);
    rd_chk(32'h0000_f000);
  endtask : t_direct
  task automatic t_indirect();
    wr(1'b1, 1'b0, 32'hffff_ffff);
    ctx_rsv = 1'b1;
    wr(1'b0, 1'b1, 32'h0000_0000);
    rd_chk(32'h000f_f000);
    ctx_rsv = 1'b0;
    wr(1'b0, 1'b1, 32'h0000_00a5);
    rd_chk(32'h000f_f0a5);
  endtask : t_indirect
  task automatic t_func();
    ctx_rsv = 1'b1;
    wr(1'b1, 1'b0, 32'hffff_ffff);
    @(negedge mclk);
    chk("func_q", 32'hfff0_000f, func_q);
    rd_chk(32'hffff_f0ff);
    ctx_rsv = 1'b0;
    @(negedge mclk);
    @(negedge mclk);
    chk("func_q", 32'hfff0_00ff, func_q);
  endtask : t_func
  // Mid-run reset must bring storage back to its reset value
  task automatic t_reset();
    wr(1'b1, 1'b0, 32'hffff_ffff);
    nrst = 1'b0;
    repeat (2) @(negedge mclk);
    nrst = 1'b1;
    chk("func_q", 32'h0000_0000, func_q);
    rd_chk(32'h0000_f000);
  endtask : t_reset
  initial begin
    nrst = 1'b0;
    ctx_rsv = 1'b0;
    req = '0;
    repeat (8) @(negedge mclk);
    nrst = 1'b1;
    t_direct();
    t_indirect();
    t_func();
    t_reset();
    finish_test();
  end
endmodule : rsb_reg_test
